/* File: src/clock_switch_defines.vh */
// Register map, field positions, reset values and timing counts for the clock switch.
// Assumes a 20 MHz core clock and a 32-bit APB slave with word-aligned registers.
`ifndef CLOCK_SWITCH_DEFINES_VH
`define CLOCK_SWITCH_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_SWITCH_REQUEST      12'h000
`define OFS_CURRENT_STATUS      12'h004
`define OFS_CONTROL_STATUS      12'h008
`define OFS_MANUAL_OSC_ENABLE   12'h00C
`define OFS_IRQ_STATUS          12'h010
`define OFS_IRQ_MASK            12'h014
`define OFS_POWER_CONTROL       12'h018

// ****************************************
// Field positions
// ****************************************
`define SRC_W                   3
`define DIV_W                   4
`define REQ_DIV_LSB             0
`define REQ_SRC_LSB             4
`define CTL_HOLD_BIT            7
`define CTL_READY_BIT           4
`define CTL_NEW_READY_BIT       3
`define IRQ_DONE_BIT            0
`define IRQ_FAIL_BIT            1
`define PWR_DOZE_BIT            0
`define MANUAL_OSC_ENABLE_REG_LSB               2

// ****************************************
// Reset values and source codes
// ****************************************
`define RST_SOURCE              3'h6
`define RST_DIVIDER             4'h0
`define SRC_PLL_A               3'h1
`define SRC_PLL_B               3'h2

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS           50
`define PLL_LOCK_LIMIT_US       100
`define PLL_LOCK_CYCLES         ((`PLL_LOCK_LIMIT_US * 1000) / `CLK_PERIOD_NS)

`endif

/* File: src/system_clock_switch.v */
// System clock source and post-divider switch controller with an APB register file.
// Assumes oscillator ready and PLL lock levels synchronous to core_clk_i; the
// glitch-free mux itself is downstream and follows the select/pause outputs.
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "clock_switch_defines.vh"

module system_clock_switch #(
    parameter PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
    input  wire        core_clk_i,
    input  wire        reset_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire [7:0]  osc_ready_i,
    input  wire        pll_lock_i,
    input  wire        sleep_i,
    output reg  [7:0]  osc_enable_o,
    output reg  [2:0]  clock_select_o,
    output reg  [3:0]  divider_select_o,
    output reg  [2:0]  pll_input_select_o,
    output reg         system_pause_o,
    output reg         failsafe_trigger_o,
    output reg         irq_o
);

    // ****************************************
    // State encoding
    // ****************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_LOCK = 2'h2;
    localparam ST_SLP  = 2'h3;

    localparam [19:0] LOCK_MAX = PLL_LOCK_CYCLES;

    function is_pll;
        input [2:0] src;
        begin
            is_pll = (src == `SRC_PLL_A) || (src == `SRC_PLL_B);
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    reg [2:0]  requested_source;
    reg [3:0]  requested_divider;
    reg [2:0]  current_source;
    reg [3:0]  current_divider;
    reg        switch_hold;
    reg        new_source_ready;
    reg        clock_settled;
    reg        doze_enable;
    reg [5:0]  manual_osc_enable;
    reg [1:0]  irq_status;
    reg [1:0]  irq_mask;
    reg [1:0]  state;
    reg [19:0] lock_count;
    reg        was_asleep;

    wire       wr_access = psel_i & penable_i & pwrite_i;
    wire       rd_access = psel_i & penable_i & ~pwrite_i;
    wire       mapped    = (paddr_i == `OFS_SWITCH_REQUEST) || (paddr_i == `OFS_CURRENT_STATUS)
                        || (paddr_i == `OFS_CONTROL_STATUS) || (paddr_i == `OFS_MANUAL_OSC_ENABLE)
                        || (paddr_i == `OFS_IRQ_STATUS) || (paddr_i == `OFS_IRQ_MASK)
                        || (paddr_i == `OFS_POWER_CONTROL);
    wire       wr_req    = wr_access & (paddr_i == `OFS_SWITCH_REQUEST);

    // Same source and divider means nothing pending
    wire       pending   = (requested_source != current_source)
                        || (requested_divider != current_divider);
    // Running source or divider-only change is ready without waiting
    wire       src_ready = (requested_source == current_source)
                        || osc_ready_i[requested_source];
    wire       pll_swap  = is_pll(requested_source) && is_pll(current_source)
                        && (requested_source != current_source);

    reg        ev_done;
    reg        ev_fail;

    // ****************************************
    // Switch sequencer
    // ****************************************
    // Doze gates only the CPU, so this runs every cycle regardless
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state              <= ST_IDLE;
            current_source     <= `RST_SOURCE;
            current_divider    <= `RST_DIVIDER;
            new_source_ready   <= 1'b0;
            clock_settled      <= 1'b1;
            lock_count         <= 20'h00000;
            system_pause_o     <= 1'b0;
            pll_input_select_o <= `RST_SOURCE;
            was_asleep         <= 1'b0;
            ev_done            <= 1'b0;
            ev_fail            <= 1'b0;
        end else begin
            ev_done <= 1'b0;
            ev_fail <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (sleep_i) begin
                        state <= ST_SLP;
                    end else if (pending) begin
                        clock_settled <= 1'b0;
                        state         <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (sleep_i) begin
                        // Switch held over to wake, sleep entered normally
                        new_source_ready <= 1'b0;
                        state            <= ST_SLP;
                    end else if (!pending) begin
                        // Request rewritten to current setting: abandoned
                        new_source_ready <= 1'b0;
                        clock_settled    <= 1'b1;
                        state            <= ST_IDLE;
                    end else if (!new_source_ready) begin
                        if (src_ready) begin
                            new_source_ready <= 1'b1;
                            ev_done          <= ~was_asleep | ~switch_hold;
                        end
                    end else if (!switch_hold) begin
                        was_asleep <= 1'b0;
                        if (pll_swap) begin
                            system_pause_o     <= 1'b1;
                            pll_input_select_o <= requested_source;
                            lock_count         <= 20'h00000;
                            state              <= ST_LOCK;
                        end else begin
                            current_source   <= requested_source;
                            current_divider  <= requested_divider;
                            clock_settled    <= 1'b1;
                            new_source_ready <= 1'b0;
                            if (is_pll(requested_source)) begin
                                pll_input_select_o <= requested_source;
                            end
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_LOCK: begin
                    lock_count <= lock_count + 20'h00001;
                    if (pll_lock_i || lock_count == LOCK_MAX) begin
                        ev_fail          <= ~pll_lock_i;
                        system_pause_o   <= 1'b0;
                        current_source   <= requested_source;
                        current_divider  <= requested_divider;
                        clock_settled    <= 1'b1;
                        new_source_ready <= 1'b0;
                        state            <= ST_IDLE;
                    end
                end
                ST_SLP: begin
                    if (!sleep_i) begin
                        if (pending && !switch_hold) begin
                            // Wake directly on the new clock
                            current_source  <= requested_source;
                            current_divider <= requested_divider;
                            if (is_pll(requested_source)) begin
                                pll_input_select_o <= requested_source;
                            end
                            clock_settled <= 1'b1;
                            ev_done       <= 1'b1;
                            state         <= ST_IDLE;
                        end else if (pending) begin
                            // Old clock, request reissued
                            was_asleep <= 1'b1;
                            state      <= ST_WAIT;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // APB register file
    // ****************************************
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            requested_source  <= `RST_SOURCE;
            requested_divider <= `RST_DIVIDER;
            switch_hold       <= 1'b0;
            doze_enable       <= 1'b0;
            manual_osc_enable <= 6'h00;
            irq_status        <= 2'h0;
            irq_mask          <= 2'h0;
            prdata_o          <= 32'h00000000;
            pready_o          <= 1'b0;
            pslverr_o         <= 1'b0;
        end else begin
            // Access phase answered after one wait state
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
            if (wr_req && !pready_o) begin
                requested_source  <= pwdata_i[`REQ_SRC_LSB +: `SRC_W];
                requested_divider <= pwdata_i[`REQ_DIV_LSB +: `DIV_W];
            end
            if (wr_access && !pready_o) begin
                case (paddr_i)
                    `OFS_CONTROL_STATUS:    switch_hold       <= pwdata_i[`CTL_HOLD_BIT];
                    `OFS_MANUAL_OSC_ENABLE: manual_osc_enable <= pwdata_i[7:`MANUAL_OSC_ENABLE_REG_LSB];
                    `OFS_IRQ_MASK:          irq_mask          <= pwdata_i[1:0];
                    `OFS_POWER_CONTROL:     doze_enable       <= pwdata_i[`PWR_DOZE_BIT];
                    default: ;
                endcase
            end
            // Set wins over a write-one clear in the same cycle
            irq_status <= (irq_status & ~((wr_access && !pready_o &&
                           paddr_i == `OFS_IRQ_STATUS) ? pwdata_i[1:0] : 2'h0))
                        | {ev_fail, ev_done};
            if (rd_access && !pready_o) begin
                case (paddr_i)
                    `OFS_SWITCH_REQUEST:    prdata_o <= {25'h0, requested_source, requested_divider};
                    `OFS_CURRENT_STATUS:    prdata_o <= {25'h0, current_source, current_divider};
                    `OFS_CONTROL_STATUS:    prdata_o <= {24'h0, switch_hold, 2'h0, clock_settled,
                                                         new_source_ready, 3'h0};
                    `OFS_MANUAL_OSC_ENABLE: prdata_o <= {24'h0, manual_osc_enable, 2'h0};
                    `OFS_IRQ_STATUS:        prdata_o <= {30'h0, irq_status};
                    `OFS_IRQ_MASK:          prdata_o <= {30'h0, irq_mask};
                    `OFS_POWER_CONTROL:     prdata_o <= {31'h0, doze_enable};
                    default:                prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Requested source is powered while waiting so the old one keeps running
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            osc_enable_o       <= 8'h00;
            clock_select_o     <= `RST_SOURCE;
            divider_select_o   <= `RST_DIVIDER;
            failsafe_trigger_o <= 1'b0;
            irq_o              <= 1'b0;
        end else begin
            // Manual requests sit in bits 7..2, matching their register layout
            osc_enable_o <= ({manual_osc_enable, 2'h0} | (8'h01 << current_source)
                           | ((state == ST_WAIT) ? (8'h01 << requested_source) : 8'h00));
            // Select only moves when the mux is told to; the mux hands over on
            // a low phase of both clocks so no runt pulse reaches the core
            clock_select_o     <= current_source;
            divider_select_o   <= current_divider;
            failsafe_trigger_o <= ev_fail;
            irq_o              <= |(irq_status & irq_mask);
        end
    end

endmodule

/* File: verif/clock_switch_monitor.sv */
// Checker for the clock switch: bus handshake, pause, fail-safe and sleep.
// Sees only the top-level ports; bound into every system_clock_switch.
module clock_switch_monitor #(
    parameter PLL_LOCK_CYCLES = 2000
) (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        sleep_i,
    input wire logic [2:0]  clock_select_o,
    input wire logic        system_pause_o,
    input wire logic        failsafe_trigger_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // ****************************************
    // Pause length counter
    // ****************************************
    // A counter, since the lock limit is far beyond a delay range
    logic [15:0] pause_cnt;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) pause_cnt <= 16'h0000;
        else pause_cnt <= system_pause_o ? pause_cnt + 16'h0001 : 16'h0000;
    end
    a_ready_follows: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access phase not answered in one cycle");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (!psel_i |=> !pready_o)
        else $error("pready without a request");
    a_error_needs_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_unmapped_reads_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_pause_bounded: assert property (pause_cnt <= PLL_LOCK_CYCLES + 2)
        else $error("pause outlasts lock limit");
    a_failsafe_single: assert property (failsafe_trigger_o |=> !failsafe_trigger_o)
        else $error("fail-safe pulse too long");
    a_failsafe_after_pause: assert property ($rose(failsafe_trigger_o) |-> $past(system_pause_o, 2))
        else $error("fail-safe without pause");
    a_sleep_holds_clock: assert property (sleep_i && $past(sleep_i) |-> $stable(clock_select_o))
        else $error("clock changed during sleep");
endmodule
bind system_clock_switch clock_switch_monitor #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_mon (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sleep_i(sleep_i), .clock_select_o(clock_select_o), .system_pause_o(system_pause_o),
    .failsafe_trigger_o(failsafe_trigger_o));

/* File: verif/tb.sv */
// Self-checking bench for the clock switch, driven over APB.
// Assumes the defines header is on the include path; lock limit shortened to 20.
`include "clock_switch_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i, reset_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rdat;
    logic        pready_o, pslverr_o, pll_lock_i, sleep_i, rerr;
    logic [7:0]  osc_ready_i, osc_enable_o;
    logic [2:0]  clock_select_o, pll_input_select_o;
    logic [3:0]  divider_select_o;
    logic        system_pause_o, failsafe_trigger_o, irq_o, saw_pause, saw_fail;
    int          fail_count, samples_checked;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d, x; logic e;} row_t;
    row_t rows [6];
    system_clock_switch #(.PLL_LOCK_CYCLES(20)) DUT (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .osc_ready_i(osc_ready_i),
        .pll_lock_i(pll_lock_i), .sleep_i(sleep_i), .osc_enable_o(osc_enable_o),
        .clock_select_o(clock_select_o), .divider_select_o(divider_select_o),
        .pll_input_select_o(pll_input_select_o), .system_pause_o(system_pause_o),
        .failsafe_trigger_o(failsafe_trigger_o), .irq_o(irq_o));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Master holds the whole request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) chk(0, 1, "no pready");
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string what);
        apb(1'b0, a, 32'h0);
        chk(rdat, x, what);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
    initial begin
        reset_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 12'h000;
        pwdata_i = 32'h0; osc_ready_i = 8'h40; pll_lock_i = 1'b0; sleep_i = 1'b0;
        rows[0] = {1'b0, `OFS_SWITCH_REQUEST, 32'h0, 32'h00000060, 1'b0};
        rows[1] = {1'b0, `OFS_CURRENT_STATUS, 32'h0, 32'h00000060, 1'b0};
        rows[2] = {1'b1, `OFS_MANUAL_OSC_ENABLE, 32'h000000FF, 32'h0, 1'b0};
        rows[3] = {1'b0, `OFS_MANUAL_OSC_ENABLE, 32'h0, 32'h000000FC, 1'b0};
        rows[4] = {1'b0, 12'h0FC, 32'h0, 32'h0, 1'b1};
        rows[5] = {1'b0, `OFS_IRQ_STATUS, 32'h0, 32'h0, 1'b0};
        cyc(2);
        reset_i <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rdat, rows[i].x, "row read");
            if (!rows[i].w) chk(rerr, rows[i].e, "row error");
        end
        chk(osc_enable_o[7:2], 6'h3F, "manual enables");
        $display("test registers done");
        // Held switch to a source that is not yet ready
        apb(1'b1, `OFS_CONTROL_STATUS, 32'h00000080);
        apb(1'b1, `OFS_IRQ_MASK, 32'h00000001);
        apb(1'b1, `OFS_SWITCH_REQUEST, 32'h00000032);
        cyc(5);
        rd(`OFS_CURRENT_STATUS, 32'h60, "waiting current");
        osc_ready_i[3] <= 1'b1;
        cyc(4);
        rd(`OFS_CONTROL_STATUS, 32'h88, "held control");
        chk(irq_o, 1'b1, "irq raised");
        rd(`OFS_CURRENT_STATUS, 32'h60, "held current");
        apb(1'b1, `OFS_CONTROL_STATUS, 32'h0);
        cyc(3);
        rd(`OFS_CURRENT_STATUS, 32'h32, "switched current");
        rd(`OFS_CONTROL_STATUS, 32'h10, "settled control");
        chk({clock_select_o, divider_select_o}, 7'h32, "select outputs");
        apb(1'b1, `OFS_IRQ_STATUS, 32'h00000001);
        cyc(2);
        chk(irq_o, 1'b0, "irq cleared");
        $display("test hold done");
        // Divider-only change while doze is on
        apb(1'b1, `OFS_POWER_CONTROL, 32'h00000001);
        apb(1'b1, `OFS_SWITCH_REQUEST, 32'h00000035);
        cyc(4);
        rd(`OFS_CURRENT_STATUS, 32'h35, "divider only");
        rd(`OFS_IRQ_STATUS, 32'h1, "done flag");
        apb(1'b1, `OFS_IRQ_STATUS, 32'h00000001);
        $display("test divider done");
        // Sleep before completion, wake with hold clear
        osc_ready_i[0] <= 1'b0;
        apb(1'b1, `OFS_SWITCH_REQUEST, 32'h00000001);
        sleep_i <= 1'b1;
        cyc(4);
        chk(clock_select_o, 3'h3, "sleep keeps old");
        sleep_i <= 1'b0;
        cyc(4);
        rd(`OFS_CURRENT_STATUS, 32'h01, "wake new");
        rd(`OFS_IRQ_STATUS, 32'h1, "wake flag");
        // Wake with hold set stays on the old clock until hold clears
        apb(1'b1, `OFS_CONTROL_STATUS, 32'h00000080);
        apb(1'b1, `OFS_SWITCH_REQUEST, 32'h00000010);
        sleep_i <= 1'b1;
        cyc(3);
        sleep_i <= 1'b0;
        osc_ready_i[1] <= 1'b1;
        pll_lock_i <= 1'b1;
        cyc(4);
        rd(`OFS_CURRENT_STATUS, 32'h01, "wake old");
        apb(1'b1, `OFS_CONTROL_STATUS, 32'h0);
        cyc(4);
        rd(`OFS_CURRENT_STATUS, 32'h10, "on pll");
        $display("test sleep done");
        // PLL input change with no lock: pause, then fail-safe
        osc_ready_i[2] <= 1'b1;
        pll_lock_i <= 1'b0;
        saw_pause = 1'b0;
        saw_fail = 1'b0;
        apb(1'b1, `OFS_SWITCH_REQUEST, 32'h00000020);
        repeat (60) begin
            @(negedge core_clk_i);
            saw_pause |= system_pause_o;
            saw_fail |= failsafe_trigger_o;
        end
        chk(saw_pause, 1'b1, "pause seen");
        chk(saw_fail, 1'b1, "fail-safe seen");
        rd(`OFS_IRQ_STATUS, 32'h3, "lock fail flag");
        chk(pll_input_select_o, 3'h2, "pll input");
        $display("test pll done");
        // Held switch abandoned by copying the current setting back
        apb(1'b1, `OFS_CONTROL_STATUS, 32'h00000080);
        apb(1'b1, `OFS_SWITCH_REQUEST, 32'h00000000);
        cyc(3);
        apb(1'b1, `OFS_SWITCH_REQUEST, 32'h00000020);
        cyc(3);
        rd(`OFS_CONTROL_STATUS, 32'h90, "abandoned control");
        rd(`OFS_CURRENT_STATUS, 32'h20, "abandoned current");
        $display("test abandon done");
        // Mid-run reset returns the reset source
        reset_i <= 1'b1;
        cyc(2);
        reset_i <= 1'b0;
        chk(clock_select_o, 3'h6, "reset source");
        rd(`OFS_SWITCH_REQUEST, 32'h60, "reset request");
        $display("test reset done");
        close_out();
    end
endmodule
